// File: test_signal_observation_mux_test.sv
// Testbench for tsom_top: Wishbone tasks, one task per scenario, verdict.
// Assumes tsom_src_model supplies the source levels.
`timescale 1ns/1ps
module test_signal_observation_mux_test;
   reg         clk_i = 1'b0;
   reg         rst_i = 1'b1;
   reg         cyc = 1'b0, stb = 1'b0, we = 1'b0, e;
   reg  [3:0]  adr = 4'h0, sel = 4'h0;
   reg  [31:0] dat = 32'h0, rd;
   reg  [11:0] pat = 12'h000;
   wire [11:0] src;
   wire [31:0] dat_o;
   wire        ack_o, err_o, pin, aux_en;
   wire [3:0]  aux_sel;
   integer     n_mismatch = 0, num_checks = 0, i;
   always #5 clk_i = ~clk_i;
   tsom_src_model src_m (.clk_i(clk_i), .pat_i(pat), .src_o(src));
   tsom_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .tx_envelope_i(src[0]),
      .tx_nrz_i(src[1]), .rx_man_sub_i(src[2]), .rx_man_i(src[3]), .rx_data_i(src[4]), .rx_valid_i(src[5]),
      .rx_coll_i(src[6]), .coder_clk_i(src[7]), .rx_clk_i(src[8]), .transmitting_i(src[9]),
      .rd_sync_i(src[10]), .wr_sync_i(src[11]), .mux_output_pin_o(pin), .aux_sel_o(aux_sel), .aux_en_o(aux_en));
   task chk(input [31:0] got, input [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected t=%0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task wb(input w, input [3:0] a, input [31:0] d, input [3:0] s);
      integer k;
      begin
         @(posedge clk_i);
         {cyc, stb, we, adr, dat, sel} <= {2'h3, w, a, d, s};
         k = 0;
         do begin
            @(posedge clk_i);
            k = k + 1;
         end while (ack_o !== 1'b1 && err_o !== 1'b1 && k < 50);
         rd = dat_o;
         e = err_o;
         {cyc, stb} <= 2'h0;
         if (k >= 50) n_mismatch = n_mismatch + 1;
         @(posedge clk_i);
      end
   endtask
   // Source pattern takes one edge in the model, one in the pin register
   task obs(input [11:0] p, input x);
      begin
         @(posedge clk_i);
         pat <= p;
         repeat (3) @(posedge clk_i);
         chk(pin, x);
      end
   endtask
   task t_regs;
      begin
         wb(1'b0, 4'h4, 32'h0, 4'hF);
         chk(rd, 32'h0);
         wb(1'b1, 4'h4, 32'h5, 4'hE);
         wb(1'b0, 4'h4, 32'h0, 4'hF);
         chk(rd, 32'h0);
         wb(1'b1, 4'h0, 32'hA5, 4'hF);
         wb(1'b0, 4'h0, 32'h0, 4'hF);
         chk(rd, 32'hA5);
         wb(1'b0, 4'hC, 32'h0, 4'hF);
         chk(e, 1'b1);
         // Only the low byte is kept; upper write bits must read back zero
         wb(1'b1, 4'h4, 32'hFFFFFF31, 4'hF);
         wb(1'b0, 4'h4, 32'h0, 4'hF);
         chk(rd, 32'h31);
         chk(e, 1'b0);
         // Select 1 gives a high pin; analog code 3 is routed and enabled
         wb(1'b0, 4'h8, 32'h0, 4'hF);
         chk(rd, 32'h27);
      end
   endtask
   task t_serial;
      integer k;
      begin
         for (i = 0; i < 8; i = i + 1) begin
            wb(1'b1, 4'h4, i, 4'hF);
            k = (i >= 2 && i <= 5) ? i - 2 : 0;
            obs(12'h001 << k, i >= 1 && i <= 5);
            obs(~(12'h001 << k), i == 1);
         end
      end
   endtask
   task probe(input [7:0] c, input [11:0] pa, input [11:0] pb, input xa, input xb);
      begin
         wb(1'b1, 4'h0, {24'h0, c}, 4'hF);
         obs(pa, xa);
         obs(pb, xb);
      end
   endtask
   task t_probe;
      begin
         wb(1'b1, 4'h4, 32'h9, 4'hF);
         probe(8'hF4, 12'h010, 12'hFEF, 1'b1, 1'b0);
         probe(8'hE4, 12'h020, 12'hFDF, 1'b1, 1'b0);
         probe(8'hD4, 12'h060, 12'h040, 1'b1, 1'b0);
         probe(8'hC4, 12'h280, 12'h300, 1'b1, 1'b0);
         probe(8'hC4, 12'h100, 12'h080, 1'b1, 1'b0);
         probe(8'hB5, 12'h400, 12'hBFF, 1'b1, 1'b0);
         probe(8'hA5, 12'h800, 12'h7FF, 1'b1, 1'b0);
         probe(8'h00, 12'h000, 12'hFFF, 1'b1, 1'b1);
         probe(8'h55, 12'hFFF, 12'h000, 1'b0, 1'b0);
         wb(1'b1, 4'h0, 32'h96, 4'hF);
         // A clock on the pin must change level at every edge
         for (i = 0; i < 4; i = i + 1) begin
            e = pin;
            @(posedge clk_i);
            chk(pin ^ e, 1'b1);
         end
         wb(1'b1, 4'h0, 32'h0, 4'hF);
         wb(1'b0, 4'h0, 32'h0, 4'hF);
         chk(rd, 32'h0);
      end
   endtask
   task t_ana;
      begin
         for (i = 0; i < 16; i = i + 1) begin
            wb(1'b1, 4'h4, i << 4, 4'hF);
            repeat (3) @(posedge clk_i);
            chk({aux_en, aux_sel}, i <= 12 ? 16 + i : 0);
         end
      end
   endtask
   task complete_run;
      begin
         $display("checks %0d mismatches %0d", num_checks, n_mismatch);
         if (n_mismatch == 0 && num_checks > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs;
      t_serial;
      t_probe;
      t_ana;
      complete_run;
   end
   initial begin
      #100000;
      n_mismatch = n_mismatch + 1;
      complete_run;
   end
endmodule

// File: tsom_defines.vh
// Constants for the test signal observation mux: register map, fields, codes.
// Assumes inclusion by bare name from the design files; definitions only.
// What this block does
// RULE1: Route disabled: serial select 0 drives pin low, 1 drives high; 6,7 reserved.
// RULE2: Route disabled, serial select 3: pin shows transmit data in NRZ form.
// RULE3: Route disabled, serial select 2: pin shows Miller-coded transmit envelope.
// RULE4: Serial select 4: pin shows received Manchester signal with subcarrier.
// RULE5: Serial select 5: pin shows received Manchester signal without subcarrier.
// RULE6: Route enable 1: pin follows digital probe selector, serial select ignored; the code still uses the serial select for probe 00.
// RULE7: Probe F4 received data, E4 receive-valid strobe, D4 collision indicator.
// RULE8: Probe C4 serial clock: coder clock transmitting, receiver clock receiving.
// RULE9: Probe B5 synchronised read strobe, A5 synchronised write strobe.
// RULE10: Probe 96 outputs the internal system clock; the code shows clk/2 from a flop that toggles every clock.
// RULE11: Probe 00 selects nothing; pin carries serial switch choice.
// RULE12: Valid probe high while data and collision valid; collision high on collision; the code shows collision only while valid is high.
// RULE13: Software writes probe config 00 when not observing test signals.
// RULE14: Software writes only listed probe codes; others reserved for production.
// RULE15: 4-bit analog select routes node 0..C to aux pin; D..F reserved.
// RULE16: Reserved serial selects and unlisted probe codes drive the pin low.
`ifndef TSOM_DEFINES_VH
`define TSOM_DEFINES_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define TSOM_ADDR_PROBE   4'h0
`define TSOM_ADDR_CTRL    4'h4
`define TSOM_ADDR_STATUS  4'h8

// ----------------------------------------
// Control fields and reset values
// ----------------------------------------
`define TSOM_CTRL_SEL_LSB    0
`define TSOM_CTRL_SEL_MSB    2
`define TSOM_CTRL_ROUTE_BIT  3
`define TSOM_CTRL_ANA_LSB    4
`define TSOM_CTRL_ANA_MSB    7
`define TSOM_PROBE_RESET     8'h00
`define TSOM_SEL_RESET       3'h0
`define TSOM_ANA_RESET       4'h0

// ----------------------------------------
// Serial switch selects
// ----------------------------------------
`define TSOM_SEL_LOW       3'h0
`define TSOM_SEL_HIGH      3'h1
`define TSOM_SEL_ENVELOPE  3'h2
`define TSOM_SEL_NRZ       3'h3
`define TSOM_SEL_MAN_SUB   3'h4
`define TSOM_SEL_MAN       3'h5

// ----------------------------------------
// Digital probe codes
// ----------------------------------------
`define TSOM_PRB_DATA     8'hF4
`define TSOM_PRB_VALID    8'hE4
`define TSOM_PRB_COLL     8'hD4
`define TSOM_PRB_SCLK     8'hC4
`define TSOM_PRB_RDSYNC   8'hB5
`define TSOM_PRB_WRSYNC   8'hA5
`define TSOM_PRB_SYSCLK   8'h96
`define TSOM_PRB_NONE     8'h00

// ----------------------------------------
// Analog select range
// ----------------------------------------
`define TSOM_ANA_LAST     4'hC

`endif

// File: tsom_mux_core.v
// Combinational signal selection for the observation pins.
// Assumes all source signals are synchronous to the caller's clock.
`timescale 1ns/1ps
`include "tsom_defines.vh"

module tsom_mux_core (
   input  wire        route_en_i,
   input  wire [2:0]  sel_i,
   input  wire [7:0]  probe_i,
   input  wire [3:0]  ana_sel_i,
   input  wire        tx_envelope_i,
   input  wire        tx_nrz_i,
   input  wire        rx_man_sub_i,
   input  wire        rx_man_i,
   input  wire        rx_data_i,
   input  wire        rx_valid_i,
   input  wire        rx_coll_i,
   input  wire        coder_clk_i,
   input  wire        rx_clk_i,
   input  wire        transmitting_i,
   input  wire        rd_sync_i,
   input  wire        wr_sync_i,
   input  wire        sys_clk_tick_i,
   output reg         pin_o,
   output reg  [3:0]  aux_sel_o,
   output reg         aux_en_o
);

   reg serial_bit;
   reg probe_bit;

   always @* begin
      case (sel_i)
         `TSOM_SEL_LOW:      serial_bit = 1'b0;           // RULE1
         `TSOM_SEL_HIGH:     serial_bit = 1'b1;           // RULE1
         `TSOM_SEL_ENVELOPE: serial_bit = tx_envelope_i;  // RULE3
         `TSOM_SEL_NRZ:      serial_bit = tx_nrz_i;       // RULE2
         `TSOM_SEL_MAN_SUB:  serial_bit = rx_man_sub_i;   // RULE4
         `TSOM_SEL_MAN:      serial_bit = rx_man_i;       // RULE5
         default:            serial_bit = 1'b0;           // RULE16
      endcase
   end

   always @* begin
      case (probe_i)
         `TSOM_PRB_DATA:   probe_bit = rx_data_i;                     // RULE7
         `TSOM_PRB_VALID:  probe_bit = rx_valid_i;                    // RULE12
         `TSOM_PRB_COLL:   probe_bit = rx_coll_i & rx_valid_i;        // RULE12
         `TSOM_PRB_SCLK:   probe_bit = transmitting_i ? coder_clk_i
                                                      : rx_clk_i;     // RULE8
         `TSOM_PRB_RDSYNC: probe_bit = rd_sync_i;                     // RULE9
         `TSOM_PRB_WRSYNC: probe_bit = wr_sync_i;                     // RULE9
         `TSOM_PRB_SYSCLK: probe_bit = sys_clk_tick_i;                // RULE10
         `TSOM_PRB_NONE:   probe_bit = serial_bit;                    // RULE11
         default:          probe_bit = 1'b0;                          // RULE16
      endcase
   end

   always @* begin
      pin_o = route_en_i ? probe_bit : serial_bit;  // RULE6
      // Reserved analog codes leave the aux pin unrouted
      aux_en_o  = (ana_sel_i <= `TSOM_ANA_LAST);    // RULE15
      aux_sel_o = aux_en_o ? ana_sel_i : 4'h0;      // RULE15
   end

endmodule

// File: tsom_src_model.sv
// Source side model: the twelve signal levels the mux observes.
// Assumes the bench sets a pattern; levels move one edge later.
`timescale 1ns/1ps
module tsom_src_model (
   input  wire        clk_i,
   input  wire [11:0] pat_i,
   output reg  [11:0] src_o
);
   always @(posedge clk_i) begin
      src_o <= pat_i;
   end
endmodule

// File: tsom_top.v
// Test signal observation mux with classic Wishbone register slave.
// Assumes one clock, synchronous active-high reset, sources synchronous to clk_i.
//
// The implementer's own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`include "tsom_defines.vh"

module tsom_top (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        cyc_i,
   input  wire        stb_i,
   input  wire        we_i,
   input  wire [3:0]  adr_i,
   input  wire [3:0]  sel_i,
   input  wire [31:0] dat_i,
   output reg  [31:0] dat_o,
   output reg         ack_o,
   output reg         err_o,
   input  wire        tx_envelope_i,
   input  wire        tx_nrz_i,
   input  wire        rx_man_sub_i,
   input  wire        rx_man_i,
   input  wire        rx_data_i,
   input  wire        rx_valid_i,
   input  wire        rx_coll_i,
   input  wire        coder_clk_i,
   input  wire        rx_clk_i,
   input  wire        transmitting_i,
   input  wire        rd_sync_i,
   input  wire        wr_sync_i,
   output reg         mux_output_pin_o,
   output reg  [3:0]  aux_sel_o,
   output reg         aux_en_o
);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg  [7:0] digital_probe_config_reg;
   reg  [2:0] serial_switch_select_reg;
   reg        test_route_enable_reg;
   reg  [3:0] analog_probe_select_reg;
   reg        sys_tick_reg;
   wire       pin_next;
   wire [3:0] aux_sel_next;
   wire       aux_en_next;

   wire req    = cyc_i & stb_i & ~ack_o & ~err_o;
   wire hit_pr = (adr_i == `TSOM_ADDR_PROBE);
   wire hit_ct = (adr_i == `TSOM_ADDR_CTRL);
   wire hit_st = (adr_i == `TSOM_ADDR_STATUS);
   wire mapped = hit_pr | hit_ct | hit_st;

   // ----------------------------------------
   // Bus slave: one wait-free answer a cycle after request
   // ----------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o                    <= 1'b0;
         err_o                    <= 1'b0;
         dat_o                    <= 32'h0000_0000;
         digital_probe_config_reg <= `TSOM_PROBE_RESET;
         serial_switch_select_reg <= `TSOM_SEL_RESET;
         test_route_enable_reg    <= 1'b0;
         analog_probe_select_reg  <= `TSOM_ANA_RESET;
      end else begin
         ack_o <= req & mapped;
         err_o <= req & ~mapped;
         dat_o <= 32'h0000_0000;
         if (req & mapped & we_i & sel_i[0]) begin
            if (hit_pr)
               digital_probe_config_reg <= dat_i[7:0];
            if (hit_ct) begin
               serial_switch_select_reg <= dat_i[`TSOM_CTRL_SEL_MSB:`TSOM_CTRL_SEL_LSB];
               test_route_enable_reg    <= dat_i[`TSOM_CTRL_ROUTE_BIT];
               analog_probe_select_reg  <= dat_i[`TSOM_CTRL_ANA_MSB:`TSOM_CTRL_ANA_LSB];
            end
         end
         if (req & mapped & ~we_i) begin
            if (hit_pr)
               dat_o <= {24'h000000, digital_probe_config_reg};
            if (hit_ct)
               dat_o <= {24'h000000, analog_probe_select_reg,
                         test_route_enable_reg, serial_switch_select_reg};
            // Status shows the live pin and aux routing
            if (hit_st)
               dat_o <= {26'h0000000, aux_en_o, aux_sel_o, mux_output_pin_o};
         end
      end
   end

   // ----------------------------------------
   // System clock probe
   // ----------------------------------------
   // A flop can only show clk/2; real clock gating on a pin is avoided
   always @(posedge clk_i) begin
      if (rst_i)
         sys_tick_reg <= 1'b0;
      else
         sys_tick_reg <= ~sys_tick_reg;  // RULE10
   end

   tsom_mux_core u_core (
      .route_en_i     (test_route_enable_reg),
      .sel_i          (serial_switch_select_reg),
      .probe_i        (digital_probe_config_reg),
      .ana_sel_i      (analog_probe_select_reg),
      .tx_envelope_i  (tx_envelope_i),
      .tx_nrz_i       (tx_nrz_i),
      .rx_man_sub_i   (rx_man_sub_i),
      .rx_man_i       (rx_man_i),
      .rx_data_i      (rx_data_i),
      .rx_valid_i     (rx_valid_i),
      .rx_coll_i      (rx_coll_i),
      .coder_clk_i    (coder_clk_i),
      .rx_clk_i       (rx_clk_i),
      .transmitting_i (transmitting_i),
      .rd_sync_i      (rd_sync_i),
      .wr_sync_i      (wr_sync_i),
      .sys_clk_tick_i (sys_tick_reg),
      .pin_o          (pin_next),
      .aux_sel_o      (aux_sel_next),
      .aux_en_o       (aux_en_next)
   );

   // ----------------------------------------
   // Registered pins
   // ----------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         mux_output_pin_o <= 1'b0;
         aux_sel_o        <= 4'h0;
         aux_en_o         <= 1'b0;
      end else begin
         mux_output_pin_o <= pin_next;      // RULE6
         aux_sel_o        <= aux_sel_next;  // RULE15
         aux_en_o         <= aux_en_next;   // RULE15
      end
   end

endmodule

// File: tsom_top_monitor.sv
// Checker for tsom_top: pin routing and analog select per shadowed setting.
// Assumes it is bound onto tsom_top; one clock domain.
`timescale 1ns/1ps
module tsom_top_monitor (
   input wire        clk_i,
   input wire        rst_i,
   input wire        we_i,
   input wire [3:0]  adr_i,
   input wire [3:0]  sel_i,
   input wire [31:0] dat_i,
   input wire        ack_o,
   input wire        tx_envelope_i, tx_nrz_i, rx_man_sub_i, rx_man_i, rx_data_i, rx_valid_i,
   input wire        rx_coll_i, coder_clk_i, rx_clk_i, transmitting_i, rd_sync_i, wr_sync_i,
   input wire        mux_output_pin_o,
   input wire [3:0]  aux_sel_o,
   input wire        aux_en_o
);
   reg  [7:0]  prb_reg;
   reg  [7:0]  ctl_reg;
   reg  [11:0] q;
   reg  [1:0]  qt_reg;
   wire        rt = ctl_reg[3];
   wire [2:0]  s = ctl_reg[2:0];
   wire [3:0]  an = ctl_reg[7:4];
   wire        ok = qt_reg == 2'h3;
   wire        p = mux_output_pin_o;
   // Only judge once a register write has had time to reach the pin
   always @(posedge clk_i) begin
      q <= {wr_sync_i, rd_sync_i, transmitting_i, rx_clk_i, coder_clk_i, rx_coll_i,
            rx_valid_i, rx_data_i, rx_man_i, rx_man_sub_i, tx_nrz_i, tx_envelope_i};
      if (rst_i) begin
         prb_reg <= 8'h00;
         ctl_reg <= 8'h00;
         qt_reg <= 2'h0;
      end else begin
         qt_reg <= ack_o ? 2'h0 : (ok ? qt_reg : qt_reg + 2'h1);
         if (ack_o && we_i && sel_i[0] && adr_i == 4'h0) prb_reg <= dat_i[7:0];
         if (ack_o && we_i && sel_i[0] && adr_i == 4'h4) ctl_reg <= dat_i[7:0];
      end
   end
   AST_FIXED: assert property (@(posedge clk_i) disable iff (rst_i)
      ok && !rt && s < 3'h2 |-> p == s[0]) else $error("pin not at fixed level");
   AST_ENV: assert property (@(posedge clk_i) disable iff (rst_i)
      ok && !rt && s == 3'h2 |-> p == q[0]) else $error("envelope not on pin");
   AST_NRZ: assert property (@(posedge clk_i) disable iff (rst_i)
      ok && !rt && s == 3'h3 |-> p == q[1]) else $error("nrz not on pin");
   AST_MSUB: assert property (@(posedge clk_i) disable iff (rst_i)
      ok && !rt && s == 3'h4 |-> p == q[2]) else $error("manchester sub not on pin");
   AST_MAN: assert property (@(posedge clk_i) disable iff (rst_i)
      ok && !rt && s == 3'h5 |-> p == q[3]) else $error("manchester not on pin");
   AST_RX: assert property (@(posedge clk_i) disable iff (rst_i)
      ok && rt && (prb_reg == 8'hF4 || prb_reg == 8'hE4 || prb_reg == 8'hD4) |->
      p == (prb_reg == 8'hF4 ? q[4] : prb_reg == 8'hE4 ? q[5] : q[6] & q[5])) else $error("rx probe");
   AST_SCLK: assert property (@(posedge clk_i) disable iff (rst_i)
      ok && rt && prb_reg == 8'hC4 |-> p == (q[9] ? q[7] : q[8])) else $error("serial clock probe");
   AST_SYNC: assert property (@(posedge clk_i) disable iff (rst_i)
      ok && rt && (prb_reg == 8'hB5 || prb_reg == 8'hA5) |-> p == (prb_reg[4] ? q[10] : q[11]))
      else $error("sync strobe probe");
   AST_NONE: assert property (@(posedge clk_i) disable iff (rst_i)
      ok && rt && prb_reg == 8'h00 && s < 3'h2 |-> p == s[0]) else $error("probe 00 not serial");
   AST_RSV: assert property (@(posedge clk_i) disable iff (rst_i)
      ok && (rt ? !(prb_reg inside {8'hF4, 8'hE4, 8'hD4, 8'hC4, 8'hB5, 8'hA5, 8'h96, 8'h00}) : s > 3'h5)
      |-> !p) else $error("reserved code not low");
   AST_ANA: assert property (@(posedge clk_i) disable iff (rst_i)
      ok |-> aux_en_o == (an <= 4'hC) && aux_sel_o == (an <= 4'hC ? an : 4'h0)) else $error("aux select");
   AST_SYSCLK: assert property (@(posedge clk_i) disable iff (rst_i)
      ok && rt && prb_reg == 8'h96 |-> p != $past(p)) else $error("system clock probe not toggling");
endmodule
bind tsom_top tsom_top_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .we_i(we_i), .adr_i(adr_i),
   .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .tx_envelope_i(tx_envelope_i), .tx_nrz_i(tx_nrz_i),
   .rx_man_sub_i(rx_man_sub_i), .rx_man_i(rx_man_i), .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i),
   .rx_coll_i(rx_coll_i), .coder_clk_i(coder_clk_i), .rx_clk_i(rx_clk_i), .transmitting_i(transmitting_i),
   .rd_sync_i(rd_sync_i), .wr_sync_i(wr_sync_i), .mux_output_pin_o(mux_output_pin_o),
   .aux_sel_o(aux_sel_o), .aux_en_o(aux_en_o));
